/* logic/tes_defines.svh */
// Register indices, field positions, reset values and timing for the envelope shaper
`ifndef TES_DEFINES_SVH
`define TES_DEFINES_SVH

`define TES_IDX_FGUARD_A 10'h014
`define TES_IDX_RGUARD_A 10'h015
`define TES_IDX_SHAPE_A 10'h020
`define TES_IDX_DRIVE_A 10'h021
`define TES_IDX_RGUARD_B 10'h054
`define TES_IDX_FGUARD_B 10'h058
`define TES_IDX_DRIVE_B 10'h104
`define TES_IDX_AMPL_B 10'h108
`define TES_IDX_SHAPE_B 10'h128
`define TES_IDX_STATUS 10'h130

`define TES_GUARD_EN_BIT 0
`define TES_GUARD_LEN_LSB 1
`define TES_GUARD_PAT_LSB 16
`define TES_SHAPE_RESID_LSB 0
`define TES_SHAPE_RGLVL_LSB 8
`define TES_SHAPE_SKIP_BIT 16
`define TES_SHAPE_SLEW_LSB 17
`define TES_SHAPE_FTAU_LSB 20
`define TES_SHAPE_RTAU_LSB 24
`define TES_DRV_TMODE_LSB 0
`define TES_DRV_MMODE_LSB 4

`define TES_GUARD_RESET 32'h0000_0000
`define TES_SHAPE_RESET 32'h0000_001f
`define TES_DRIVE_RESET 32'h0000_0017
`define TES_MODE_BOTH 3'h7
`define TES_MODE_LOW_ONLY 3'h5
`define TES_MODE_FULL_AM 3'h1
`define TES_LEVEL_MAX 5'h1f
`define TES_TAU_MAX 4'hf

`define TES_CLK_PERIOD_NS 25
`define TES_UNIT_NS 200
`define TES_UNIT_CYCLES ((`TES_UNIT_NS + `TES_CLK_PERIOD_NS - 1) / `TES_CLK_PERIOD_NS)

`endif

/* logic/tes_pkg.sv */
// Types shared by the envelope shaper
package tes_pkg;
    typedef enum logic [1:0] {
        TES_CARRIER = 2'b00,
        TES_FALL = 2'b01,
        TES_MOD = 2'b11,
        TES_RISE = 2'b10
    } tes_state_t;

    typedef enum logic [3:0] {
        TES_R_NONE,
        TES_R_FGUARD,
        TES_R_RGUARD,
        TES_R_SHAPE,
        TES_R_DRIVE,
        TES_R_AMPL,
        TES_R_SHAPE_B,
        TES_R_STATUS
    } tes_reg_t;
endpackage

/* logic/tes_shaper.sv */
// Transmit envelope shaping control with Wishbone register access
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "tes_defines.svh"

module tes_shaper
    import tes_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic mod_req,
    input wire logic signed [3:0] gear_fall_delta,
    input wire logic signed [3:0] gear_rise_delta,
    input wire logic signed [3:0] gear_level_delta,
    output logic [1:0] drv_phase,
    output logic drv_push_en,
    output logic drv_pull_en,
    output logic drv_pattern,
    output logic [4:0] drv_level,
    output logic [3:0] drv_fall_tau,
    output logic drv_fall_tau_en,
    output logic [3:0] drv_rise_tau,
    output logic drv_rise_shape_en,
    output logic [2:0] drv_slew
);

    localparam logic [7:0] UNIT_CYC = 8'(`TES_UNIT_CYCLES);

    // Address decode, used by both read and write paths
    function automatic tes_reg_t decode(input logic [9:0] idx);
        tes_reg_t r;
        r = TES_R_NONE;
        if (idx == `TES_IDX_FGUARD_A || idx == `TES_IDX_FGUARD_B) begin
            r = TES_R_FGUARD;
        end else if (idx == `TES_IDX_RGUARD_A || idx == `TES_IDX_RGUARD_B) begin
            r = TES_R_RGUARD;
        end else if (idx == `TES_IDX_SHAPE_A) begin
            r = TES_R_SHAPE;
        end else if (idx == `TES_IDX_SHAPE_B) begin
            r = TES_R_SHAPE_B;
        end else if (idx == `TES_IDX_DRIVE_A || idx == `TES_IDX_DRIVE_B) begin
            r = TES_R_DRIVE;
        end else if (idx == `TES_IDX_AMPL_B) begin
            r = TES_R_AMPL;
        end else if (idx == `TES_IDX_STATUS) begin
            r = TES_R_STATUS;
        end
        return r;
    endfunction

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[i*8 +: 8] = wr[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // Saturating add of a gear delta; used for both time constants and the level
    function automatic logic [4:0] gear_adj(input logic [4:0] base, input logic signed [3:0] dlt,
                                            input logic [4:0] top);
        logic signed [6:0] s;
        logic [4:0] r;
        s = $signed({2'b00, base}) + 7'(dlt);
        if (s < 0) begin
            r = 5'h00;
        end else if (s > $signed({2'b00, top})) begin
            r = top;
        end else begin
            r = s[4:0];
        end
        return r;
    endfunction

    // Register file
    logic [31:0] fguard_q, fguard_d;
    logic [31:0] rguard_q, rguard_d;
    logic [31:0] shape_q, shape_d;
    logic [31:0] drive_q, drive_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    tes_state_t state_q, state_d;
    tes_reg_t acc_sel;
    logic acc_req;

    assign acc_req = wb_cyc_i && wb_stb_i;
    assign acc_sel = decode(wb_adr_i[11:2]);

    always_comb begin
        fguard_d = fguard_q;
        rguard_d = rguard_q;
        shape_d = shape_q;
        drive_d = drive_q;
        ack_d = acc_req && !ack_q;
        rdat_d = rdat_q;
        // Write lands at the edge where the master sees ack
        if (acc_req && ack_q && wb_we_i) begin
            case (acc_sel)
                TES_R_FGUARD: fguard_d = merge(fguard_q, wb_dat_i, wb_sel_i);
                TES_R_RGUARD: rguard_d = merge(rguard_q, wb_dat_i, wb_sel_i);
                TES_R_SHAPE: shape_d = merge(shape_q, wb_dat_i, wb_sel_i);
                TES_R_DRIVE: drive_d = merge(drive_q, wb_dat_i, wb_sel_i);
                TES_R_AMPL: shape_d[6:0] = wb_sel_i[0] ? wb_dat_i[6:0] : shape_q[6:0];
                TES_R_SHAPE_B: begin
                    shape_d = merge(shape_q, wb_dat_i, wb_sel_i);
                    shape_d[6:0] = shape_q[6:0];
                end
                default: begin
                end
            endcase
        end
        if (acc_req && !ack_q) begin
            case (acc_sel)
                TES_R_FGUARD: rdat_d = fguard_q;
                TES_R_RGUARD: rdat_d = rguard_q;
                TES_R_SHAPE: rdat_d = shape_q;
                TES_R_DRIVE: rdat_d = drive_q;
                TES_R_AMPL: rdat_d = {25'h0, shape_q[6:0]};
                TES_R_SHAPE_B: rdat_d = {shape_q[31:7], 7'h00};
                TES_R_STATUS: rdat_d = {22'h0, drv_level, drv_pattern, drv_pull_en,
                                        drv_push_en, state_q};
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fguard_q <= `TES_GUARD_RESET;
            rguard_q <= `TES_GUARD_RESET;
            shape_q <= `TES_SHAPE_RESET;
            drive_q <= `TES_DRIVE_RESET;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            fguard_q <= fguard_d;
            rguard_q <= rguard_d;
            shape_q <= shape_d;
            drive_q <= drive_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Pulse snapshot: taken only when a pulse starts, so mid-pulse writes wait
    logic fg_en_q, fg_en_d;
    logic [3:0] fg_len_q, fg_len_d;
    logic [15:0] fg_pat_q, fg_pat_d;
    logic rg_en_q, rg_en_d;
    logic [3:0] rg_len_q, rg_len_d;
    logic [15:0] rg_pat_q, rg_pat_d;
    logic [4:0] resid_q, resid_d;
    logic [4:0] rg_lvl_q, rg_lvl_d;
    logic skip_q, skip_d;
    logic [2:0] slew_q, slew_d;
    logic [3:0] ftau_q, ftau_d;
    logic [3:0] rtau_q, rtau_d;
    logic [2:0] tmode_q, tmode_d;
    logic [2:0] mmode_q, mmode_d;
    logic [7:0] cyc_q, cyc_d;
    logic [4:0] unit_q, unit_d;
    logic req_q, req_d;
    logic [4:0] resid_field;
    logic [4:0] rg_field;
    logic unit_end;
    logic [4:0] rise_units;

    // Seven-bit field, only 0..0x1f meaningful; larger codes saturate
    assign resid_field = (shape_q[`TES_SHAPE_RESID_LSB +: 7] > 7'h1f) ? `TES_LEVEL_MAX
                         : shape_q[`TES_SHAPE_RESID_LSB +: 5];
    assign rg_field = (shape_q[`TES_SHAPE_RGLVL_LSB +: 7] > 7'h1f) ? `TES_LEVEL_MAX
                      : shape_q[`TES_SHAPE_RGLVL_LSB +: 5];
    assign unit_end = (cyc_q == UNIT_CYC - 8'h01);
    // Skipped shaper ends the rise after one unit unless a rising guard is longer
    assign rise_units = skip_q ? 5'h01 : {1'b0, rtau_q} + 5'h01;

    always_comb begin
        state_d = state_q;
        fg_en_d = fg_en_q;
        fg_len_d = fg_len_q;
        fg_pat_d = fg_pat_q;
        rg_en_d = rg_en_q;
        rg_len_d = rg_len_q;
        rg_pat_d = rg_pat_q;
        resid_d = resid_q;
        rg_lvl_d = rg_lvl_q;
        skip_d = skip_q;
        slew_d = slew_q;
        ftau_d = ftau_q;
        rtau_d = rtau_q;
        tmode_d = tmode_q;
        mmode_d = mmode_q;
        req_d = mod_req;
        cyc_d = unit_end ? 8'h00 : cyc_q + 8'h01;
        unit_d = unit_end ? unit_q + 5'h01 : unit_q;
        case (state_q)
            TES_CARRIER: begin
                cyc_d = 8'h00;
                unit_d = 5'h00;
                if (mod_req && !req_q) begin
                    fg_en_d = fguard_q[`TES_GUARD_EN_BIT];
                    fg_len_d = fguard_q[`TES_GUARD_LEN_LSB +: 4];
                    fg_pat_d = fguard_q[`TES_GUARD_PAT_LSB +: 16];
                    rg_en_d = rguard_q[`TES_GUARD_EN_BIT];
                    rg_len_d = rguard_q[`TES_GUARD_LEN_LSB +: 4];
                    rg_pat_d = rguard_q[`TES_GUARD_PAT_LSB +: 16];
                    resid_d = gear_adj(resid_field, gear_level_delta, `TES_LEVEL_MAX);
                    rg_lvl_d = rg_field;
                    skip_d = shape_q[`TES_SHAPE_SKIP_BIT];
                    slew_d = shape_q[`TES_SHAPE_SLEW_LSB +: 3];
                    ftau_d = 4'(gear_adj({1'b0, shape_q[`TES_SHAPE_FTAU_LSB +: 4]},
                                         gear_fall_delta, 5'(`TES_TAU_MAX)));
                    rtau_d = 4'(gear_adj({1'b0, shape_q[`TES_SHAPE_RTAU_LSB +: 4]},
                                         gear_rise_delta, 5'(`TES_TAU_MAX)));
                    tmode_d = drive_q[`TES_DRV_TMODE_LSB +: 3];
                    mmode_d = drive_q[`TES_DRV_MMODE_LSB +: 3];
                    // Guard only when enabled, else straight into modulation
                    state_d = fguard_q[`TES_GUARD_EN_BIT] ? TES_FALL : TES_MOD;
                end
            end
            TES_FALL: begin
                if (unit_end && unit_q == {1'b0, fg_len_q}) begin
                    state_d = TES_MOD;
                end
            end
            TES_MOD: begin
                cyc_d = 8'h00;
                unit_d = 5'h00;
                if (!mod_req) begin
                    state_d = TES_RISE;
                end
            end
            TES_RISE: begin
                if (unit_end && unit_q + 5'h01 >= rise_units
                    && !(rg_en_q && unit_q < {1'b0, rg_len_q})) begin
                    state_d = TES_CARRIER;
                end
            end
            default: state_d = TES_CARRIER;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= TES_CARRIER;
            fg_en_q <= 1'b0;
            fg_len_q <= 4'h0;
            fg_pat_q <= 16'h0000;
            rg_en_q <= 1'b0;
            rg_len_q <= 4'h0;
            rg_pat_q <= 16'h0000;
            resid_q <= `TES_LEVEL_MAX;
            rg_lvl_q <= 5'h00;
            skip_q <= 1'b0;
            slew_q <= 3'h0;
            ftau_q <= 4'h0;
            rtau_q <= 4'h0;
            tmode_q <= `TES_MODE_BOTH;
            mmode_q <= `TES_MODE_FULL_AM;
            cyc_q <= 8'h00;
            unit_q <= 5'h00;
            req_q <= 1'b0;
        end else begin
            state_q <= state_d;
            fg_en_q <= fg_en_d;
            fg_len_q <= fg_len_d;
            fg_pat_q <= fg_pat_d;
            rg_en_q <= rg_en_d;
            rg_len_q <= rg_len_d;
            rg_pat_q <= rg_pat_d;
            resid_q <= resid_d;
            rg_lvl_q <= rg_lvl_d;
            skip_q <= skip_d;
            slew_q <= slew_d;
            ftau_q <= ftau_d;
            rtau_q <= rtau_d;
            tmode_q <= tmode_d;
            mmode_q <= mmode_d;
            cyc_q <= cyc_d;
            unit_q <= unit_d;
            req_q <= req_d;
        end
    end

    // Output stage drive, registered so the analog side never sees decode glitches
    logic [1:0] o_phase_q, o_phase_d;
    logic o_push_q, o_push_d;
    logic o_pull_q, o_pull_d;
    logic o_pat_q, o_pat_d;
    logic [4:0] o_lvl_q, o_lvl_d;
    logic [3:0] o_ftau_q, o_ftau_d;
    logic o_ftau_en_q, o_ftau_en_d;
    logic [3:0] o_rtau_q, o_rtau_d;
    logic o_rshape_q, o_rshape_d;
    logic [2:0] o_slew_q, o_slew_d;
    logic rg_active;

    assign rg_active = rg_en_q && unit_q <= {1'b0, rg_len_q};

    always_comb begin
        o_phase_d = state_q;
        o_push_d = 1'b1;
        o_pull_d = 1'b1;
        o_pat_d = 1'b0;
        o_lvl_d = `TES_LEVEL_MAX;
        o_slew_d = slew_q;
        o_rtau_d = rtau_q;
        o_rshape_d = !skip_q;
        o_ftau_d = ftau_q;
        // Low-side-only mode has no falling constant, so gear tweaks vanish there
        o_ftau_en_d = (tmode_q == `TES_MODE_BOTH) && !skip_q;
        case (state_q)
            TES_CARRIER: begin
                o_lvl_d = `TES_LEVEL_MAX;
            end
            TES_FALL: begin
                o_pat_d = fg_pat_q[unit_q[3:0]];
                o_push_d = tmode_q[1];
                o_pull_d = tmode_q[2];
                if (tmode_q == `TES_MODE_BOTH) begin
                    o_lvl_d = resid_q;
                end else begin
                    o_lvl_d = 5'h00;
                end
            end
            TES_MOD: begin
                o_push_d = mmode_q[1];
                o_pull_d = mmode_q[2];
                o_lvl_d = (mmode_q == `TES_MODE_FULL_AM) ? 5'h00 : resid_q;
            end
            TES_RISE: begin
                if (rg_active) begin
                    o_pat_d = rg_pat_q[unit_q[3:0]];
                    o_push_d = tmode_q[1];
                    o_pull_d = tmode_q[2];
                    o_lvl_d = rg_lvl_q;
                end else begin
                    o_lvl_d = resid_q;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            o_phase_q <= 2'b00;
            o_push_q <= 1'b1;
            o_pull_q <= 1'b1;
            o_pat_q <= 1'b0;
            o_lvl_q <= `TES_LEVEL_MAX;
            o_ftau_q <= 4'h0;
            o_ftau_en_q <= 1'b0;
            o_rtau_q <= 4'h0;
            o_rshape_q <= 1'b0;
            o_slew_q <= 3'h0;
        end else begin
            o_phase_q <= o_phase_d;
            o_push_q <= o_push_d;
            o_pull_q <= o_pull_d;
            o_pat_q <= o_pat_d;
            o_lvl_q <= o_lvl_d;
            o_ftau_q <= o_ftau_d;
            o_ftau_en_q <= o_ftau_en_d;
            o_rtau_q <= o_rtau_d;
            o_rshape_q <= o_rshape_d;
            o_slew_q <= o_slew_d;
        end
    end

    assign drv_phase = o_phase_q;
    assign drv_push_en = o_push_q;
    assign drv_pull_en = o_pull_q;
    assign drv_pattern = o_pat_q;
    assign drv_level = o_lvl_q;
    assign drv_fall_tau = o_ftau_q;
    assign drv_fall_tau_en = o_ftau_en_q;
    assign drv_rise_tau = o_rtau_q;
    assign drv_rise_shape_en = o_rshape_q;
    assign drv_slew = o_slew_q;

endmodule // tes_shaper

/* tb/tes_shaper_props.sv */
// Port-level checks on the envelope shaper
`timescale 1ns/1ps
module tes_shaper_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic mod_req,
    input wire logic [1:0] drv_phase,
    input wire logic drv_push_en,
    input wire logic drv_pull_en,
    input wire logic [4:0] drv_level,
    input wire logic drv_fall_tau_en,
    input wire logic drv_rise_shape_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Guard length counter, cleared outside the guard phase
    logic [7:0] gcnt_q;
    logic [7:0] gcnt_d;
    always_comb gcnt_d = (drv_phase == 2'b01) ? gcnt_q + 8'h01 : 8'h00;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) gcnt_q <= 8'h00;
        else gcnt_q <= gcnt_d;
    end
    sequence s_start;
        drv_phase == 2'b00 ##1 drv_phase != 2'b00;
    endsequence
    sequence s_stop;
        drv_phase == 2'b11 ##1 drv_phase == 2'b10;
    endsequence
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_phase_order: assert property (
        $changed(drv_phase) |-> {$past(drv_phase), drv_phase} inside {4'h1, 4'h3, 4'h7, 4'he, 4'h8})
        else $error("illegal phase step");
    a_start_delay: assert property (
        $rose(mod_req) && drv_phase == 2'b00 |-> ##1 s_start)
        else $error("pulse did not start two edges after request");
    a_stop_delay: assert property (
        $fell(mod_req) && drv_phase == 2'b11 |-> ##1 s_stop)
        else $error("rise did not follow request drop");
    a_mod_hold: assert property (
        drv_phase == 2'b11 && mod_req && $past(mod_req) |=> drv_phase == 2'b11)
        else $error("modulation left while requested");
    a_guard_units: assert property (
        drv_phase != 2'b01 && gcnt_q != 8'h00 |-> gcnt_q[2:0] == 3'h0 && gcnt_q <= 8'h80)
        else $error("guard not a whole number of units");
    a_carrier_drive: assert property (
        drv_phase == 2'b00 |-> drv_push_en && drv_pull_en && drv_level == 5'h1f)
        else $error("carrier not fully driven");
    a_low_side: assert property (
        drv_phase == 2'b01 && !drv_push_en |-> drv_pull_en && drv_level == 5'h00 && !drv_fall_tau_en)
        else $error("low side guard wrong");
    a_tau_gate: assert property (drv_fall_tau_en |-> drv_rise_shape_en)
        else $error("fall constant active with shaper skipped");
endmodule // tes_shaper_props

bind tes_shaper tes_shaper_props u_props (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .mod_req, .drv_phase, .drv_push_en, .drv_pull_en, .drv_level, .drv_fall_tau_en,
    .drv_rise_shape_en);

/* tb/tes_stage_model.sv */
// Behavioural output stage that records what each pulse phase drove
`timescale 1ns/1ps
module tes_stage_model (
    input wire logic core_clk,
    input wire logic [1:0] drv_phase,
    input wire logic drv_push_en,
    input wire logic drv_pull_en,
    input wire logic drv_pattern,
    input wire logic [4:0] drv_level,
    input wire logic [3:0] drv_fall_tau
);
    // Snapshots of the last pulse, read by the bench
    int guard_cyc = 0;
    int rise_cyc = 0;
    int pat_cyc = 0;
    logic [4:0] guard_lvl = 5'h00;
    logic [4:0] mod_lvl = 5'h00;
    logic [4:0] rise_lvl = 5'h00;
    logic guard_push = 1'b0;
    logic guard_pull = 1'b0;
    logic [3:0] guard_ftau = 4'h0;
    logic [1:0] last = 2'b00;
    logic start;
    // A pulse never leaves carrier straight into the rise phase
    assign start = (last == 2'b00) && (drv_phase != 2'b00);
    always @(posedge core_clk) begin
        last <= drv_phase;
        rise_cyc <= start ? 0 : rise_cyc + int'(drv_phase == 2'b10);
        guard_cyc <= (start ? 0 : guard_cyc) + int'(drv_phase == 2'b01);
        pat_cyc <= (start ? 0 : pat_cyc) + int'(drv_phase == 2'b01 && drv_pattern);
        case (drv_phase)
            2'b01: begin
                guard_lvl <= drv_level;
                guard_push <= drv_push_en;
                guard_pull <= drv_pull_en;
                guard_ftau <= drv_fall_tau;
            end
            2'b11: mod_lvl <= drv_level;
            2'b10: rise_lvl <= drv_level;
            default: ;
        endcase
    end
endmodule // tes_stage_model

/* tb/testbench.sv */
// Self-checking bench for the envelope shaper
`timescale 1ns/1ps
`include "tes_defines.svh"
module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rcap;
    logic ack;
    logic mod_req = 1'b0;
    logic signed [3:0] fdel = 4'sh0;
    logic signed [3:0] rdel = 4'sh0;
    logic signed [3:0] ldel = 4'sh0;
    logic [1:0] phase;
    logic push;
    logic pull;
    logic ftau_en;
    logic rshape;
    logic [4:0] lvl;
    logic [3:0] ftau;
    logic [3:0] rtau;
    logic pat;
    logic [2:0] slew;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int len;

    tes_shaper i_dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .mod_req(mod_req), .gear_fall_delta(fdel), .gear_rise_delta(rdel),
        .gear_level_delta(ldel), .drv_phase(phase), .drv_push_en(push), .drv_pull_en(pull),
        .drv_pattern(pat), .drv_level(lvl), .drv_fall_tau(ftau), .drv_fall_tau_en(ftau_en),
        .drv_rise_tau(rtau), .drv_rise_shape_en(rshape), .drv_slew(slew));
    tes_stage_model m (.core_clk(core_clk), .drv_phase(phase), .drv_push_en(push),
        .drv_pull_en(pull), .drv_pattern(pat), .drv_level(lvl), .drv_fall_tau(ftau));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    // Whole run is some 2200 cycles; the ceiling leaves ample room
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Holds the request until ack is sampled high at an edge
    task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'hf;
        wdat <= d;
        do @(posedge core_clk); while (ack !== 1'b1);
        rcap = rdat;
        cyc <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 32'h0);
        check(rcap, exp, what);
    endtask
    // Hold covers the longest guard so the modulated phase is always reached
    task automatic pulse();
        mod_req <= 1'b1;
        repeat (140) @(posedge core_clk);
        mod_req <= 1'b0;
        repeat (2) @(posedge core_clk);
        while (phase !== 2'b00) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd_chk(`TES_IDX_FGUARD_A, 32'h0, "guard reset");
        rd_chk(`TES_IDX_SHAPE_A, 32'h1f, "shape reset");
        rd_chk(`TES_IDX_DRIVE_A, 32'h17, "drive reset");
        wr(10'h3ff, 32'hffff_ffff);
        rd_chk(10'h3ff, 32'h0, "unmapped");
        wr(`TES_IDX_RGUARD_A, 32'h0);
        wr(`TES_IDX_SHAPE_A, 32'h0340_001e);
        rd_chk(`TES_IDX_AMPL_B, 32'h1e, "amplitude alias");
        rd_chk(`TES_IDX_SHAPE_B, 32'h0340_0000, "shape alias");
        rd_chk(`TES_IDX_STATUS, 32'h3ec, "idle status");
        $display("register test done");
        for (len = 0; len < 16; len += 5) begin
            wr(`TES_IDX_FGUARD_A, (len << 1) | 1);
            pulse();
            check(m.guard_cyc, (len + 1) * 8, "guard cycles");
            check(m.guard_lvl, 32'h1e, "guard level");
            check(m.guard_push, 32'h1, "guard push");
            check(m.guard_ftau, 32'h4, "fall constant");
            check(m.mod_lvl, 32'h0, "full am level");
            check(m.rise_cyc, 32'd32, "rise cycles");
            check(m.rise_lvl, 32'h1e, "rise start level");
            check(rtau, 32'h3, "rise constant");
        end
        $display("guard length test done");
        wr(`TES_IDX_FGUARD_A, 32'h6);
        pulse();
        check(m.guard_cyc, 32'h0, "no guard");
        wr(`TES_IDX_FGUARD_A, 32'h3);
        wr(`TES_IDX_DRIVE_A, 32'h15);
        pulse();
        check(m.guard_push, 32'h0, "low only push");
        check(m.guard_lvl, 32'h0, "low only level");
        check(m.guard_pull, 32'h1, "low only pull");
        wr(`TES_IDX_DRIVE_A, 32'h77);
        pulse();
        check(m.mod_lvl, 32'h1e, "ten percent level");
        $display("drive mode test done");
        wr(`TES_IDX_SHAPE_A, 32'h0343_001e);
        pulse();
        check(m.rise_cyc, 32'd8, "skip rise");
        check(ftau_en, 32'h0, "skip fall gate");
        check(rshape, 32'h0, "shaper skipped");
        check(slew, 32'h1, "slew snapshot");
        wr(`TES_IDX_SHAPE_A, 32'h0340_001e);
        wr(`TES_IDX_DRIVE_A, 32'h17);
        fdel <= 4'sh2;
        rdel <= 4'sh1;
        ldel <= -4'sh1;
        pulse();
        check(m.guard_ftau, 32'h6, "gear fall");
        check(m.guard_lvl, 32'h1d, "gear level");
        check(m.rise_cyc, 32'd40, "gear rise");
        check(rtau, 32'h4, "gear rise constant");
        check(rshape, 32'h1, "shaper on");
        $display("gear test done");
        fdel <= 4'sh0;
        rdel <= 4'sh0;
        ldel <= 4'sh0;
        wr(`TES_IDX_FGUARD_A, 32'h0002_0003);
        wr(`TES_IDX_RGUARD_A, 32'h0000_000b);
        wr(`TES_IDX_SHAPE_A, 32'h0340_0a1e);
        pulse();
        check(m.pat_cyc, 32'd8, "guard pattern bit");
        check(m.rise_cyc, 32'd48, "rising guard length");
        check(m.rise_lvl, 32'h0a, "rising guard level");
        wr(`TES_IDX_RGUARD_A, 32'h0);
        $display("guard pattern test done");
        wr(`TES_IDX_FGUARD_A, 32'h1f);
        mod_req <= 1'b1;
        @(posedge core_clk);
        wr(`TES_IDX_SHAPE_A, 32'h0340_0010);
        pulse();
        check(m.guard_lvl, 32'h1e, "mid pulse write held");
        pulse();
        check(m.guard_lvl, 32'h10, "write at next pulse");
        $display("boundary test done");
        print_verdict();
    end
endmodule // testbench
